// File: core/crs_map.svh
// Purpose: named constants of the core regulator start-up sequencer
// Assumes: 20 MHz system clock, 300 kHz switching frequency
// Notes: voltage targets are in 12.5 mV steps above 0 V
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH

`define CRS_SYS_CLK_KHZ 20000
`define CRS_SW_FREQ_KHZ 300
// a longest period rounds down to whole cycles
`define CRS_SW_PERIOD_CYC (`CRS_SYS_CLK_KHZ / `CRS_SW_FREQ_KHZ)
`define CRS_SW_HALF_CYC (`CRS_SW_PERIOD_CYC / 2)
`define CRS_START_DELAY_US 100
// a least time rounds up to whole cycles
`define CRS_START_DELAY_CYC ((`CRS_START_DELAY_US * `CRS_SYS_CLK_KHZ + 999) / 1000)
`define CRS_PG_DELAY_US 7000
`define CRS_PG_DELAY_CYC ((`CRS_PG_DELAY_US * `CRS_SYS_CLK_KHZ + 999) / 1000)
`define CRS_RAILS_GOOD_PERIODS 3'h6
`define CRS_BOOT_STEPS 7'h60
`define CRS_ZERO_CODE 7'h78
`define CRS_STEPS_OFF 7'h00
`define CRS_SYNC_W 13
// bit positions of the pin inputs inside the synchroniser word
`define CRS_SYNC_CODE_HI 12
`define CRS_SYNC_CODE_LO 6
`define CRS_SYNC_REG_ON 5
`define CRS_SYNC_RAILS 4
`define CRS_SYNC_NEAR_BOOT 3
`define CRS_SYNC_LOW_LOAD 2
`define CRS_SYNC_DEEP_REQ 1
`define CRS_SYNC_SLOW_WAKE 0

`endif

// File: core/crs_pkg.sv
// Purpose: types shared by the start-up sequencer files
// Assumes: nothing beyond the constants header
// Notes: numeric constants live in crs_map.svh
package crs_pkg;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_DELAY,
    ST_BOOT,
    ST_SLEW,
    ST_RUN,
    ST_LATCHED
  } crs_state_e;

  typedef logic [6:0] crs_code_t;

endpackage

// File: core/crs_phase_gen.sv
// Purpose: two interleaved switching phases, half a period apart
// Assumes: run is synchronous to sys_clk
// Notes: holds both phases low and the counter cleared while run is low
`include "crs_map.svh"

module crs_phase_gen (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // control
  input wire logic run,
  // phase timing
  output logic periodTick,
  output logic phase1Lvl,
  output logic phase2Lvl
);

  localparam logic [6:0] PERIOD_LAST = 7'(`CRS_SW_PERIOD_CYC - 1);
  localparam logic [6:0] HALF = 7'(`CRS_SW_HALF_CYC);

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic atLast;
  logic firstHalf;

  assign atLast = (cnt_r == PERIOD_LAST);
  assign cnt_nxt = (!run || atLast) ? 7'h00 : cnt_r + 7'h01;
  assign firstHalf = (cnt_r < HALF);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 7'h00;
      periodTick <= 1'b0;
      phase1Lvl <= 1'b0;
      phase2Lvl <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      periodTick <= run && atLast;
      phase1Lvl <= run && firstHalf;
      phase2Lvl <= run && !firstHalf;
    end
  end

endmodule

// File: core/crs_sequencer.sv
// Purpose: start-up and latch-off sequencer of a two-phase core regulator
// Assumes: control supply power-on reset drives nrst; pins are asynchronous
// Notes: analog slewing is outside; this block picks target, current and phases
`include "crs_map.svh"

module crs_sequencer #(
  parameter int PG_DELAY_CYC = `CRS_PG_DELAY_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // system control pins
  input wire logic regulatorOnInput,
  input wire logic systemRailsGoodInput,
  input wire logic [6:0] voltageCode,
  input wire logic lowLoadIndicatorN,
  input wire logic deepSleepRequest,
  input wire logic deepSleepSlowWakeN,
  // analog feedback: output within 10 % of the boot voltage
  input wire logic outputNearBoot,
  // system outputs
  output logic pllClockEnableN,
  output logic corePowerGood,
  // analog control
  output logic [6:0] targetSteps,
  output logic slewCurrentHigh,
  output logic slewEnable,
  output logic twoPhaseCcm,
  output logic diodeEmulation,
  output logic latchedOff,
  // gate enables
  output logic phase1Gate,
  output logic phase2Gate
);

  localparam logic [17:0] START_LAST = 18'(`CRS_START_DELAY_CYC - 1);
  localparam logic [17:0] PG_LAST = 18'(PG_DELAY_CYC - 1);

  // two-flop synchronisers for every pin input
  logic [`CRS_SYNC_W-1:0] syncA_r;
  logic [`CRS_SYNC_W-1:0] syncB_r;
  logic [`CRS_SYNC_W-1:0] pinsIn;

  assign pinsIn = {voltageCode, regulatorOnInput, systemRailsGoodInput, outputNearBoot,
                   lowLoadIndicatorN, deepSleepRequest, deepSleepSlowWakeN};

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= pinsIn;
      syncB_r <= syncA_r;
    end
  end

  crs_pkg::crs_code_t codeS;
  logic regOnS;
  logic railsGoodS;
  logic nearBootS;
  logic lowLoadNS;
  logic deepReqS;
  logic slowWakeNS;

  // code bits cross one by one, so a code change may show a mixed value for a cycle
  assign codeS = syncB_r[`CRS_SYNC_CODE_HI:`CRS_SYNC_CODE_LO];
  assign regOnS = syncB_r[`CRS_SYNC_REG_ON];
  assign railsGoodS = syncB_r[`CRS_SYNC_RAILS];
  assign nearBootS = syncB_r[`CRS_SYNC_NEAR_BOOT];
  assign lowLoadNS = syncB_r[`CRS_SYNC_LOW_LOAD];
  assign deepReqS = syncB_r[`CRS_SYNC_DEEP_REQ];
  assign slowWakeNS = syncB_r[`CRS_SYNC_SLOW_WAKE];

  // state and counters
  // two state codes are never reached; the default arm sends them to off
  crs_pkg::crs_state_e state_r;
  crs_pkg::crs_state_e state_nxt;
  logic [17:0] delayCnt_r;
  logic [17:0] delayCnt_nxt;
  logic [2:0] railsCnt_r;
  logic [2:0] railsCnt_nxt;

  logic periodTick;
  logic phase1Lvl;
  logic phase2Lvl;
  logic regulating;
  logic inBoot;
  logic inRun;
  logic afterClkEn;
  logic startDone;
  logic pgDone;
  logic bootReady;
  logic railsHold;

  assign inBoot = (state_r == crs_pkg::ST_BOOT);
  assign inRun = (state_r == crs_pkg::ST_RUN);
  assign afterClkEn = (state_r == crs_pkg::ST_SLEW) || inRun;
  assign regulating = inBoot || afterClkEn;
  assign startDone = (state_r == crs_pkg::ST_DELAY) && (delayCnt_r == START_LAST);
  assign pgDone = (state_r == crs_pkg::ST_SLEW) && (delayCnt_r == PG_LAST);
  assign railsHold = nearBootS && railsGoodS;
  assign bootReady = (railsCnt_r == `CRS_RAILS_GOOD_PERIODS);

  crs_phase_gen u_phase (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(regulating),
    .periodTick(periodTick),
    .phase1Lvl(phase1Lvl),
    .phase2Lvl(phase2Lvl)
  );

  // one counter serves both the start delay and the power-good delay
  assign delayCnt_nxt = (state_nxt != state_r) ? 18'h00000 : delayCnt_r + 18'h00001;

  // each period end reached with both conditions high since their last drop counts, so the first may be partial
  assign railsCnt_nxt = (!inBoot || !railsHold) ? 3'h0 :
                        (periodTick && !bootReady) ? railsCnt_r + 3'h1 : railsCnt_r;

  // a regulator-on drop in any active state returns to off, so the next high restarts the delay
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      crs_pkg::ST_OFF: begin
        if (regOnS) state_nxt = crs_pkg::ST_DELAY;
      end
      crs_pkg::ST_DELAY: begin
        if (!regOnS) state_nxt = crs_pkg::ST_OFF;
        else if (startDone) state_nxt = crs_pkg::ST_BOOT;
      end
      crs_pkg::ST_BOOT: begin
        if (!regOnS) state_nxt = crs_pkg::ST_OFF;
        else if (bootReady) state_nxt = crs_pkg::ST_SLEW;
      end
      crs_pkg::ST_SLEW: begin
        if (!regOnS) state_nxt = crs_pkg::ST_OFF;
        else if (!railsGoodS) state_nxt = crs_pkg::ST_LATCHED;
        else if (pgDone) state_nxt = crs_pkg::ST_RUN;
      end
      crs_pkg::ST_RUN: begin
        if (!regOnS) state_nxt = crs_pkg::ST_OFF;
        else if (!railsGoodS) state_nxt = crs_pkg::ST_LATCHED;
      end
      crs_pkg::ST_LATCHED: begin
        // the high half of the toggle is then taken in the off state
        if (!regOnS) state_nxt = crs_pkg::ST_OFF;
      end
      default: state_nxt = crs_pkg::ST_OFF;
    endcase
  end

  // code decode: linear 12.5 mV steps down from 1.5 V, floored at 0 V
  logic [6:0] codeSteps;
  logic [6:0] target_nxt;
  logic twoPhase;
  logic diodeMode;

  assign codeSteps = (codeS >= `CRS_ZERO_CODE) ? `CRS_STEPS_OFF :
                     7'(`CRS_ZERO_CODE - codeS);
  assign target_nxt = inBoot ? `CRS_BOOT_STEPS :
                      afterClkEn ? codeSteps : `CRS_STEPS_OFF;
  // mode pins only count once start-up is complete
  assign diodeMode = inRun && deepReqS && !slowWakeNS;
  assign twoPhase = !inRun || (lowLoadNS && !(deepReqS && !slowWakeNS));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= crs_pkg::ST_OFF;
      delayCnt_r <= 18'h00000;
      railsCnt_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      delayCnt_r <= delayCnt_nxt;
      railsCnt_r <= railsCnt_nxt;
    end
  end

  // registered outputs; latched and off states force everything inactive except latchedOff, which is high in the latched state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pllClockEnableN <= 1'b1;
      corePowerGood <= 1'b0;
      targetSteps <= `CRS_STEPS_OFF;
      slewCurrentHigh <= 1'b0;
      slewEnable <= 1'b0;
      twoPhaseCcm <= 1'b0;
      diodeEmulation <= 1'b0;
      latchedOff <= 1'b0;
      phase1Gate <= 1'b0;
      phase2Gate <= 1'b0;
    end else begin
      pllClockEnableN <= !afterClkEn;
      corePowerGood <= inRun;
      targetSteps <= target_nxt;
      // boot uses the low current; in run a deep-sleep request also selects the low current
      slewCurrentHigh <= (state_r == crs_pkg::ST_SLEW) || (inRun && !deepReqS);
      slewEnable <= regulating;
      twoPhaseCcm <= regulating && twoPhase;
      diodeEmulation <= diodeMode;
      latchedOff <= (state_r == crs_pkg::ST_LATCHED);
      // phase two is held off in run whenever the mode pins ask for a single phase
      phase1Gate <= regulating && phase1Lvl;
      phase2Gate <= regulating && twoPhase && phase2Lvl;
    end
  end

endmodule

// File: sim/crs_seq_assertions.sv
// Purpose: port checks of the core regulator start-up sequencer
// Assumes: bound into crs_sequencer, one clock domain
// Notes: power-good window allows two cycles early and one cycle late
module crs_seq_assertions #(
  parameter int PG_DELAY_CYC = 200
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // watched inputs
  input wire logic regulatorOnInput,
  input wire logic systemRailsGoodInput,
  input wire logic [6:0] voltageCode,
  input wire logic outputNearBoot,
  // watched outputs
  input wire logic pllClockEnableN,
  input wire logic corePowerGood,
  input wire logic [6:0] targetSteps,
  input wire logic slewCurrentHigh,
  input wire logic slewEnable,
  input wire logic twoPhaseCcm,
  input wire logic diodeEmulation,
  input wire logic latchedOff,
  input wire logic phase1Gate,
  input wire logic phase2Gate
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] pgCnt_r;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // 18 bits so the full 7 ms count also fits
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) pgCnt_r <= 18'h00000;
    else if (pllClockEnableN) pgCnt_r <= 18'h00000;
    else pgCnt_r <= pgCnt_r + 18'h00001;
  end
  sequence sBootIn;
    $rose(slewEnable);
  endsequence
  sequence sClkOn;
    $fell(pllClockEnableN);
  endsequence
  boot_entry_a: assert property (sBootIn |-> targetSteps == 7'h60 && !slewCurrentHigh)
    else $error("boot entry values wrong");
  boot_mode_a: assert property (slewEnable && !corePowerGood |-> twoPhaseCcm && !diodeEmulation)
    else $error("mode pins obeyed during start-up");
  clk_qual_a: assert property (sClkOn |-> $past(outputNearBoot, 2) && $past(systemRailsGoodInput, 2))
    else $error("clock enable without qualification");
  slew_code_a: assert property (sClkOn |-> slewCurrentHigh &&
    targetSteps == (voltageCode < 7'h78 ? 7'h78 - voltageCode : 7'h00))
    else $error("slew current or target wrong");
  pg_delay_a: assert property ($rose(corePowerGood) |->
    pgCnt_r >= PG_DELAY_CYC - 2 && pgCnt_r <= PG_DELAY_CYC + 1)
    else $error("power-good delay wrong");
  rails_latch_a: assert property ($fell(systemRailsGoodInput) && corePowerGood |-> ##[1:4] latchedOff)
    else $error("no latch-off on rails low");
  latch_out_a: assert property (latchedOff |-> !phase1Gate && !phase2Gate && pllClockEnableN && !corePowerGood)
    else $error("latched outputs wrong");
  latch_hold_a: assert property ($rose(latchedOff) |=> latchedOff [*8])
    else $error("latch left early");
  off_idle_a: assert property (!regulatorOnInput [*6] |-> !slewEnable && pllClockEnableN)
    else $error("active while regulator off");
  phase_ilv_a: assert property ($rose(phase2Gate) && $past(twoPhaseCcm) |->
    $fell(phase1Gate) ##1 (phase2Gate || !twoPhaseCcm) [*8])
    else $error("phases not interleaved");
endmodule

bind crs_sequencer crs_seq_assertions #(.PG_DELAY_CYC(PG_DELAY_CYC)) crs_seq_assertions_i (
  .sys_clk, .nrst, .regulatorOnInput, .systemRailsGoodInput, .voltageCode, .outputNearBoot,
  .pllClockEnableN, .corePowerGood, .targetSteps, .slewCurrentHigh, .slewEnable,
  .twoPhaseCcm, .diodeEmulation, .latchedOff, .phase1Gate, .phase2Gate);

// File: sim/crs_sys_model.sv
// Purpose: crude model of the regulated output seen by the comparator
// Assumes: one target step per clock, output collapses when not slewing
// Notes: far faster than real slewing, which keeps runs short
module crs_sys_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // regulator control
  input wire logic slewEnable,
  input wire logic [6:0] targetSteps,
  // comparator
  output logic outputNearBoot
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] vLvl_r;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) vLvl_r <= 7'h00;
    else if (!slewEnable) vLvl_r <= 7'h00;
    else if (vLvl_r < targetSteps) vLvl_r <= vLvl_r + 7'h01;
    else if (vLvl_r > targetSteps) vLvl_r <= vLvl_r - 7'h01;
  end
  // within 10 % of the 96-step boot level
  assign outputNearBoot = vLvl_r >= 7'h57 && vLvl_r <= 7'h69;
endmodule

// File: sim/tb_top.sv
// Purpose: self-checking bench of the start-up sequencer
// Assumes: 20 MHz clock, shortened power-good delay
// Notes: each start uses another voltage code and ends in a latch-off
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PG = 200;
  logic sys_clk, nrst, regulatorOnInput, systemRailsGoodInput;
  logic lowLoadIndicatorN, deepSleepRequest, deepSleepSlowWakeN;
  logic [6:0] voltageCode;
  logic [6:0] codes [4] = '{7'h00, 7'h60, 7'h7F, 7'h7C};
  wire logic outputNearBoot, pllClockEnableN, corePowerGood, slewCurrentHigh, slewEnable;
  wire logic twoPhaseCcm, diodeEmulation, latchedOff, phase1Gate, phase2Gate;
  wire logic [6:0] targetSteps;
  int err_count, n_compared, n;
  crs_sequencer #(.PG_DELAY_CYC(PG)) crs_sequencer_i (.sys_clk, .nrst, .regulatorOnInput,
    .systemRailsGoodInput, .voltageCode, .lowLoadIndicatorN, .deepSleepRequest,
    .deepSleepSlowWakeN, .outputNearBoot, .pllClockEnableN, .corePowerGood, .targetSteps,
    .slewCurrentHigh, .slewEnable, .twoPhaseCcm, .diodeEmulation, .latchedOff,
    .phase1Gate, .phase2Gate);
  crs_sys_model crs_sys_model_i (.sys_clk, .nrst, .slewEnable, .targetSteps, .outputNearBoot);
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task automatic step(int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask
  function automatic logic pick(int s);
    return s == 0 ? slewEnable : s == 1 ? !pllClockEnableN : s == 2 ? corePowerGood : latchedOff;
  endfunction
  task automatic wait_for(int s, int lim);
    n = 0;
    while (pick(s) !== 1'b1 && n <= lim) begin
      step(1);
      n++;
    end
    if (n > lim) begin
      err_count++;
      $display("BAD wait %0d exp 1 got 0", s);
      end_of_test();
    end
  endtask
  // mode pins held at deep sleep to show start-up ignores them
  task automatic t_start(logic [6:0] c);
    voltageCode = c;
    lowLoadIndicatorN = 1'b0;
    deepSleepRequest = 1'b1;
    deepSleepSlowWakeN = 1'b0;
    systemRailsGoodInput = 1'b1;
    regulatorOnInput = 1'b1;
    wait_for(0, 2100);
    chk("start delay", 1, n >= 2000 && n <= 2008);
    chk("boot steps", 16'h0060, targetSteps);
    chk("boot slew", 0, slewCurrentHigh);
    chk("boot ccm", 1, twoPhaseCcm);
    wait_for(1, 1500);
    chk("qual time", 1, n >= 396);
    chk("slew high", 1, slewCurrentHigh);
    chk("code steps", c < 7'h78 ? 16'h0078 - c : 16'h0000, targetSteps);
    wait_for(2, PG + 10);
    chk("pg delay", 1, n >= PG - 2);
    chk("run ccm", 0, twoPhaseCcm);
    chk("run diode", 1, diodeEmulation);
    $display("test start %0h end", c);
  endtask
  // after start-up the mode pins count: active two-phase, then one-phase CCM
  task automatic t_modes();
    deepSleepRequest = 1'b0;
    deepSleepSlowWakeN = 1'b1;
    lowLoadIndicatorN = 1'b1;
    step(4);
    chk("active ccm", 1, twoPhaseCcm);
    chk("active diode", 0, diodeEmulation);
    lowLoadIndicatorN = 1'b0;
    step(4);
    chk("one phase ccm", 0, twoPhaseCcm);
    chk("one phase gate", 0, phase2Gate);
    $display("test modes end");
  endtask
  task automatic t_latch();
    systemRailsGoodInput = 1'b0;
    wait_for(3, 6);
    chk("latch pg", 0, corePowerGood);
    chk("latch clk", 1, pllClockEnableN);
    chk("latch gates", 0, {phase1Gate, phase2Gate});
    systemRailsGoodInput = 1'b1;
    step(20);
    chk("still latched", 1, latchedOff);
    regulatorOnInput = 1'b0;
    step(8);
    chk("released", 0, latchedOff);
    $display("test latch end");
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    nrst = 1'b0;
    regulatorOnInput = 1'b0;
    systemRailsGoodInput = 1'b0;
    voltageCode = 7'h00;
    lowLoadIndicatorN = 1'b1;
    deepSleepRequest = 1'b0;
    deepSleepSlowWakeN = 1'b1;
    err_count = 0;
    n_compared = 0;
    step(16);
    nrst = 1'b1;
    step(2);
    foreach (codes[i]) begin
      t_start(codes[i]);
      t_modes();
      t_latch();
    end
    end_of_test();
  end
endmodule
